// file: oecs_chan.sv
// One channel's output sequencer: delay, relay and drive ordering.
// Assumes requests are one-cycle pulses on the system clock.
`timescale 1ns/1ns
module oecs_chan #(
    parameter int ON_RELAY_CYC = oecs_pkg::ON_RELAY_CYC,
    parameter int ON_START_CYC = oecs_pkg::ON_START_CYC,
    parameter int OFF_DRAIN_CYC = oecs_pkg::OFF_DRAIN_CYC,
    parameter int OFF_RELAY_CYC = oecs_pkg::OFF_RELAY_CYC
) (
    input wire logic mclk_in,                        // System clock.
    input wire logic arst_n_in,                      // Reset, active low.
    input wire logic on_req_in,                      // Enable request pulse.
    input wire logic off_req_in,                     // Disable request pulse.
    input wire logic keep_relays_in,                 // Leave relays alone.
    input wire logic force_off_in,                   // Immediate disable.
    input wire logic [oecs_pkg::DLY_W-1:0] rise_in,  // Turn-on delay, us.
    input wire logic [oecs_pkg::DLY_W-1:0] fall_in,  // Turn-off delay, us.
    output logic state_out,                          // 1 enabled, 0 disabled.
    output logic drive_en_out,                       // 0 forces zero V, zero I.
    output logic relay_close_out,                    // 1 closes relays.
    output logic busy_out,                           // Transition pending.
    output logic done_out                            // Completion pulse.
);
    import oecs_pkg::*;

    oecs_state_e state_q;
    oecs_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [PRE_W-1:0] pre_q;
    logic tick_q;
    logic keep_q;
    logic drive_q;
    logic relay_q;
    logic done_q;
    logic done_d;
    logic zero;

    // Microsecond tick for the programmed delays.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else if (pre_q == PRE_W'(US_CYC - 1)) begin
            pre_q <= '0;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign zero = (cnt_q == '0);

    // Next state and counter.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        case (state_q)
            OECS_OFF: begin
                if (on_req_in && !force_off_in) begin
                    state_d = OECS_ON_WAIT;
                    cnt_d = rise_in;
                end
            end
            OECS_ON_WAIT: begin
                if (force_off_in) begin
                    state_d = OECS_OFF;
                end else if (zero) begin
                    state_d = OECS_ON_RELAY;
                    cnt_d = CNT_W'(ON_RELAY_CYC);
                end else if (tick_q) begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            OECS_ON_RELAY: begin
                if (force_off_in) begin
                    state_d = OECS_OFF_DRAIN;
                    cnt_d = CNT_W'(OFF_DRAIN_CYC);
                end else if (zero) begin
                    state_d = OECS_ON_START;
                    cnt_d = CNT_W'(ON_START_CYC);
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            OECS_ON_START: begin
                if (force_off_in) begin
                    state_d = OECS_OFF_DRAIN;
                    cnt_d = CNT_W'(OFF_DRAIN_CYC);
                end else if (zero) begin
                    state_d = OECS_ON;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            OECS_ON: begin
                if (force_off_in) begin
                    state_d = OECS_OFF_DRAIN;
                    cnt_d = CNT_W'(OFF_DRAIN_CYC);
                end else if (off_req_in) begin
                    state_d = OECS_OFF_WAIT;
                    cnt_d = fall_in;
                end
            end
            OECS_OFF_WAIT: begin
                if (force_off_in || zero) begin
                    state_d = OECS_OFF_DRAIN;
                    cnt_d = CNT_W'(OFF_DRAIN_CYC);
                end else if (tick_q) begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            OECS_OFF_DRAIN: begin
                if (zero) begin
                    state_d = OECS_OFF_RELAY;
                    cnt_d = CNT_W'(OFF_RELAY_CYC);
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            OECS_OFF_RELAY: begin
                if (zero) begin
                    state_d = OECS_OFF;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = OECS_OFF;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= OECS_OFF;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            keep_q <= 1'b0;
        end else if (force_off_in) begin
            keep_q <= 1'b0;
        end else if (state_q == OECS_OFF && state_d == OECS_ON_WAIT) begin
            keep_q <= keep_relays_in;
        end else if (state_q == OECS_ON && state_d == OECS_OFF_WAIT) begin
            keep_q <= keep_relays_in;
        end
    end

    // relays move only while the output is zero.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            relay_q <= 1'b0;
        end else if (!keep_q && state_q == OECS_ON_WAIT &&
                     state_d == OECS_ON_RELAY) begin
            relay_q <= 1'b1;
        end else if (!keep_q && state_q == OECS_OFF_DRAIN &&
                     state_d == OECS_OFF_RELAY) begin
            relay_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drive_q <= 1'b0;
        end else if (state_d == OECS_ON_START) begin
            drive_q <= 1'b1;
        end else if (state_d == OECS_OFF_DRAIN || state_d == OECS_OFF) begin
            drive_q <= 1'b0;
        end
    end

    assign state_out = drive_q;
    assign drive_en_out = drive_q;
    assign relay_close_out = relay_q;
    assign busy_out = (state_q != OECS_OFF) && (state_q != OECS_ON);
    assign done_out = done_q;
endmodule

// file: oecs_pkg.sv
// Shared constants and types for the output enable coupling sequencer.
// Assumes a single 50 MHz system clock drives every module that imports it.
package oecs_pkg;

    // Channel count and widths of delay values and counters.
    localparam int NUM_CH = 4;
    localparam int DLY_W = 21;
    localparam int CNT_W = 21;
    localparam int PRE_W = 6;
    localparam int STR_W = 56;
    localparam int LEN_W = 3;

    // Clock rate and the microsecond prescaler count.
    localparam int CLK_KHZ = 50_000;
    localparam int US_CYC = CLK_KHZ / 1000;

    // Phase times of the on and off sequences, in milliseconds.
    localparam int ON_RELAY_MS = 10;
    localparam int ON_START_MS = 30;
    localparam int OFF_DRAIN_MS = 12;
    localparam int OFF_RELAY_MS = 10;

    // Phase times converted to clock cycles.
    localparam int ON_RELAY_CYC = ON_RELAY_MS * CLK_KHZ;
    localparam int ON_START_CYC = ON_START_MS * CLK_KHZ;
    localparam int OFF_DRAIN_CYC = OFF_DRAIN_MS * CLK_KHZ;
    localparam int OFF_RELAY_CYC = OFF_RELAY_MS * CLK_KHZ;

    // Largest programmable delay, in microseconds.
    localparam logic [DLY_W-1:0] DLY_MAX_US = 21'h0F_9C18;

    // Values after reset, with the offset source codes.
    localparam logic [NUM_CH-1:0] MEMBER_RST = 4'h0;
    localparam logic [DLY_W-1:0] DLY_RST = 21'h00_0000;
    localparam logic MODE_AUTO = 1'b0;
    localparam logic MODE_MANUAL = 1'b1;
    localparam logic OFFSET_MODE_RST = MODE_AUTO;

    // Characters of the membership list.
    localparam logic [7:0] ASCII_COMMA = 8'h2C;
    localparam logic [7:0] ASCII_ONE = 8'h31;

    // Channel sequencer states.
    typedef enum logic [7:0] {
        OECS_OFF       = 8'h01,
        OECS_ON_WAIT   = 8'h02,
        OECS_ON_RELAY  = 8'h04,
        OECS_ON_START  = 8'h08,
        OECS_ON        = 8'h10,
        OECS_OFF_WAIT  = 8'h20,
        OECS_OFF_DRAIN = 8'h40,
        OECS_OFF_RELAY = 8'h80
    } oecs_state_e;

endpackage

// file: oecs_stage_model.sv
// Stage model: the power stages' offset needs, channel 1 first.
// Assumes the top takes them as one packed vector in microseconds.
`timescale 1ns/1ns
module oecs_stage_model (
    output logic [83:0] stage_off_out // Offset need of each stage.
);
    // Small distinct needs, so the automatic maximum is channel 4's.
    assign stage_off_out = {21'h4, 21'h3, 21'h2, 21'h1};
endmodule

// file: oecs_sync.sv
// Two-stage synchroniser with a rising edge pulse for trigger pins.
// Assumes the pin levels are asynchronous to mclk_in.
`timescale 1ns/1ns
module oecs_sync #(
    parameter int W = 2
) (
    input wire logic mclk_in,           // System clock.
    input wire logic arst_n_in,         // Asynchronous reset, active low.
    input wire logic [W-1:0] pin_in,    // Asynchronous pin levels.
    output logic [W-1:0] rise_out       // One-cycle pulse per rising edge.
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] rise_q;

    // Two flops for the crossing, a third for edge detection.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            rise_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rise_q <= s2_q & ~s3_q;
        end
    end

    assign rise_out = rise_q;
endmodule

// file: oecs_top.sv
// Output enable coupling sequencer for a four-channel supply mainframe.
// Assumes the command parser gives one-cycle write and request pulses
// on mclk_in, and trigger pins arrive asynchronously.
//
// Operation
// - Output state bit: 1 enabled, 0 disabled.
// - Disabled channel drives zero volts, zero current.
// - Relays close on enable, open on disable.
// - Keep-relays qualifier leaves relay state unchanged.
// - Relays move only with output at zero.
// - Enable completes 35-50 ms, disable 20-25 ms.
// - State query returns 0 off, 1 on.
// - Separate turn-on and turn-off delay per channel.
// - Coupling enable bit gates the synchronisation.
// - Switching one member switches whole coupled set.
// - Couple trigger pins switch the whole set.
// - One coupled set; new list replaces old.
// - Empty membership list uncouples every channel.
// - Membership or offset writes disable all channels.
// - Membership and offset survive device reset command.
// - Membership query gives comma-separated channel list.
// - Offset 0 to 1.023 s, turn-on reference.
// - Offset only for coupled channels while enabled.
// - Offset source: automatic maximum or manual value.
// - Channel waits its delay before switching.
`timescale 1ns/1ns
module oecs_top #(
    parameter int ON_RELAY_CYC = oecs_pkg::ON_RELAY_CYC,
    parameter int ON_START_CYC = oecs_pkg::ON_START_CYC,
    parameter int OFF_DRAIN_CYC = oecs_pkg::OFF_DRAIN_CYC,
    parameter int OFF_RELAY_CYC = oecs_pkg::OFF_RELAY_CYC
) (
    input wire logic mclk_in,                          // System clock.
    input wire logic arst_n_in,                        // Reset, active low.
    input wire logic dev_reset_in,                     // Device reset pulse.
    input wire logic cmd_valid_in,                     // State request pulse.
    input wire logic cmd_on_in,                        // 1 enable, 0 disable.
    input wire logic keep_relays_qualifier_in,         // Leave relays alone.
    input wire logic [oecs_pkg::NUM_CH-1:0] cmd_chans_in,  // Channel mask.
    input wire logic rise_wr_in,                       // Write turn-on delay.
    input wire logic fall_wr_in,                       // Write turn-off delay.
    input wire logic [oecs_pkg::NUM_CH-1:0] dly_chans_in,  // Delay targets.
    input wire logic [oecs_pkg::DLY_W-1:0] dly_us_in,  // Delay value, us.
    input wire logic [1:0] dly_sel_in,                 // Channel to read back.
    input wire logic couple_en_in,                     // Coupling enable.
    input wire logic member_wr_in,                     // Write membership.
    input wire logic [oecs_pkg::NUM_CH-1:0] member_in, // New membership.
    input wire logic offset_wr_in,                     // Write offset.
    input wire logic [oecs_pkg::DLY_W-1:0] offset_us_in,   // Offset, us.
    input wire logic source_wr_in,                     // Write offset source.
    input wire logic offset_source_select_in,          // 1 manual, 0 auto.
    input wire logic [oecs_pkg::NUM_CH*oecs_pkg::DLY_W-1:0] stage_off_in,
                                                       // Per-stage need, us.
    input wire logic pin_on_trig_in,                   // On-couple pin.
    input wire logic pin_off_trig_in,                  // Off-couple pin.
    output logic [oecs_pkg::NUM_CH-1:0] state_out,     // Output state bits.
    output logic [oecs_pkg::NUM_CH-1:0] drive_en_out,  // Stage drive enable.
    output logic [oecs_pkg::NUM_CH-1:0] relay_close_out,   // Relay close.
    output logic [oecs_pkg::NUM_CH-1:0] busy_out,      // Transition pending.
    output logic [oecs_pkg::NUM_CH-1:0] done_out,      // Completion pulses.
    output logic [oecs_pkg::NUM_CH-1:0] member_out,    // Coupled set.
    output logic [oecs_pkg::STR_W-1:0] member_list_out,    // ASCII list.
    output logic [oecs_pkg::LEN_W-1:0] member_len_out, // List length, chars.
    output logic [oecs_pkg::DLY_W-1:0] offset_out,     // Programmed offset.
    output logic offset_source_select_out,             // Offset source.
    output logic [oecs_pkg::DLY_W-1:0] offset_eff_out, // Offset in use.
    output logic [oecs_pkg::DLY_W-1:0] rise_rd_out,    // Selected rise delay.
    output logic [oecs_pkg::DLY_W-1:0] fall_rd_out     // Selected fall delay.
);
    import oecs_pkg::*;

    logic [1:0] pin_rise;
    logic pin_on;
    logic pin_off;
    logic force_q;
    logic [NUM_CH-1:0] member_q;
    logic [DLY_W-1:0] offset_q;
    logic source_q;
    logic [DLY_W-1:0] auto_q;
    logic [DLY_W-1:0] rise_q [NUM_CH];
    logic [DLY_W-1:0] fall_q [NUM_CH];
    logic [DLY_W-1:0] rise_eff [NUM_CH];
    logic [NUM_CH-1:0] tgt;
    logic [NUM_CH-1:0] on_req;
    logic [NUM_CH-1:0] off_req;
    logic [NUM_CH-1:0] keep;
    logic [NUM_CH-1:0] coupled;
    logic [STR_W-1:0] list_q;
    logic [LEN_W-1:0] len_q;
    logic [DLY_W-1:0] rise_rd_q;
    logic [DLY_W-1:0] fall_rd_q;

    // Limits a programmed delay to the largest legal value.
    function automatic logic [DLY_W-1:0] clamp(input logic [DLY_W-1:0] v);
        clamp = (v > DLY_MAX_US) ? DLY_MAX_US : v;
    endfunction

    // Largest of the per-stage offsets.
    function automatic logic [DLY_W-1:0] max_off(
        input logic [NUM_CH*DLY_W-1:0] v
    );
        logic [DLY_W-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (v[i*DLY_W +: DLY_W] > m) begin
                m = v[i*DLY_W +: DLY_W];
            end
        end
        max_off = m;
    endfunction

    // Membership as ASCII digits and commas, last character lowest.
    function automatic logic [STR_W-1:0] list_str(
        input logic [NUM_CH-1:0] m
    );
        logic [STR_W-1:0] s;
        logic any;
        s = '0;
        any = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (m[i]) begin
                if (any) begin
                    s = {s[STR_W-9:0], ASCII_COMMA};
                end
                s = {s[STR_W-9:0], ASCII_ONE + 8'(i)};
                any = 1'b1;
            end
        end
        list_str = s;
    endfunction

    // Number of characters in the membership list.
    function automatic logic [LEN_W-1:0] list_len(
        input logic [NUM_CH-1:0] m
    );
        logic [LEN_W-1:0] n;
        n = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (m[i]) begin
                n = n + ((n == '0) ? LEN_W'(1) : LEN_W'(2));
            end
        end
        list_len = n;
    endfunction

    // Couple trigger pins cross into the clock domain.
    oecs_sync #(
        .W(2)
    ) u_sync (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .pin_in({pin_off_trig_in, pin_on_trig_in}),
        .rise_out(pin_rise)
    );

    assign pin_on = pin_rise[0] & couple_en_in;
    assign pin_off = pin_rise[1] & couple_en_in;

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            force_q <= 1'b0;
        end else begin
            force_q <= member_wr_in | offset_wr_in | source_wr_in |
                       dev_reset_in;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            member_q <= MEMBER_RST;
        end else if (member_wr_in) begin
            member_q <= member_in;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            offset_q <= DLY_RST;
        end else if (offset_wr_in) begin
            offset_q <= clamp(offset_us_in);
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            source_q <= OFFSET_MODE_RST;
        end else if (source_wr_in) begin
            source_q <= offset_source_select_in;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            auto_q <= DLY_RST;
        end else begin
            auto_q <= clamp(max_off(stage_off_in));
        end
    end

    // delays per channel; the device reset clears these.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < NUM_CH; i++) begin
                rise_q[i] <= DLY_RST;
                fall_q[i] <= DLY_RST;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (dev_reset_in) begin
                    rise_q[i] <= DLY_RST;
                    fall_q[i] <= DLY_RST;
                end else begin
                    if (rise_wr_in && dly_chans_in[i]) begin
                        rise_q[i] <= clamp(dly_us_in);
                    end
                    if (fall_wr_in && dly_chans_in[i]) begin
                        fall_q[i] <= clamp(dly_us_in);
                    end
                end
            end
        end
    end

    // Delay readback for the selected channel.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rise_rd_q <= DLY_RST;
            fall_rd_q <= DLY_RST;
        end else begin
            rise_rd_q <= rise_q[dly_sel_in];
            fall_rd_q <= fall_q[dly_sel_in];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            list_q <= '0;
            len_q <= '0;
        end else begin
            list_q <= list_str(member_q);
            len_q <= list_len(member_q);
        end
    end

    assign coupled = couple_en_in ? member_q : '0;
    assign tgt = ((cmd_chans_in & coupled) != '0) ?
                 (cmd_chans_in | coupled) : cmd_chans_in;

    // Requests per channel; a pin off trigger wins over on.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            off_req[i] = (cmd_valid_in && !cmd_on_in && tgt[i]) ||
                         (pin_off && coupled[i]);
            on_req[i] = !off_req[i] &&
                        ((cmd_valid_in && cmd_on_in && tgt[i]) ||
                         (pin_on && coupled[i]));
            keep[i] = cmd_valid_in && tgt[i] && keep_relays_qualifier_in;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            rise_eff[i] = coupled[i] ?
                          (offset_eff_out + rise_q[i]) : rise_q[i];
        end
    end

    // One sequencer for each channel.
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        oecs_chan #(
            .ON_RELAY_CYC(ON_RELAY_CYC),
            .ON_START_CYC(ON_START_CYC),
            .OFF_DRAIN_CYC(OFF_DRAIN_CYC),
            .OFF_RELAY_CYC(OFF_RELAY_CYC)
        ) u_chan (
            .mclk_in(mclk_in),
            .arst_n_in(arst_n_in),
            .on_req_in(on_req[g]),
            .off_req_in(off_req[g]),
            .keep_relays_in(keep[g]),
            .force_off_in(force_q),
            .rise_in(rise_eff[g]),
            .fall_in(fall_q[g]),
            .state_out(state_out[g]),
            .drive_en_out(drive_en_out[g]),
            .relay_close_out(relay_close_out[g]),
            .busy_out(busy_out[g]),
            .done_out(done_out[g])
        );
    end

    assign member_out = member_q;
    assign member_list_out = list_q;
    assign member_len_out = len_q;
    assign offset_out = offset_q;
    assign offset_source_select_out = source_q;
    assign offset_eff_out = (source_q == MODE_MANUAL) ? offset_q : auto_q;
    assign rise_rd_out = rise_rd_q;
    assign fall_rd_out = fall_rd_q;
endmodule

// file: oecs_top_sva.sv
// Checker on the top ports, watching channel 1 for sequence timing.
// Assumes the phase counts are handed on by the bind below.
`timescale 1ns/1ns
module oecs_top_sva #(
    parameter int OFF_DRAIN_CYC = 20,
    parameter int OFF_RELAY_CYC = 20
) (
    input wire logic mclk_in, // Clock.
    input wire logic arst_n_in, // Reset.
    input wire logic member_wr_in, // Write.
    input wire logic [3:0] member_in, // New set.
    input wire logic [3:0] state_out, // State.
    input wire logic [3:0] drive_en_out, // Drive.
    input wire logic [3:0] relay_close_out, // Relays.
    input wire logic [3:0] busy_out, // Busy.
    input wire logic [3:0] done_out, // Done.
    input wire logic [3:0] member_out, // Set.
    input wire logic [2:0] member_len_out // Length.
);
    localparam int OLO = OFF_DRAIN_CYC + OFF_RELAY_CYC - 2;
    localparam int OHI = OFF_DRAIN_CYC + OFF_RELAY_CYC + 3;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    property p_zero; state_out == drive_en_out; endproperty
    a_zero: assert property (p_zero) else $error("drive off");
    property p_relay;
        $changed(relay_close_out[0]) |->
            !drive_en_out[0] && !$past(drive_en_out[0]);
    endproperty
    a_relay: assert property (p_relay) else $error("relay live");
    property p_done;
        done_out[0] |-> !busy_out[0] && $past(busy_out[0]);
    endproperty
    a_done: assert property (p_done) else $error("done busy");
    property p_offt; $fell(state_out[0]) |-> ##[OLO:OHI] done_out[0]; endproperty
    a_offt: assert property (p_offt) else $error("off time");
    property p_memb; member_wr_in |=> member_out == $past(member_in); endproperty
    a_memb: assert property (p_memb) else $error("member");
    property p_force; member_wr_in |-> ##[1:4] drive_en_out == 4'h0; endproperty
    a_force: assert property (p_force) else $error("force");
    property p_len;
        member_len_out == ($past(member_out) == 4'h0 ? 3'h0 :
            3'($countones($past(member_out)) * 2 - 1));
    endproperty
    a_len: assert property (p_len) else $error("length");
    property p_on; $rose(state_out[0]) |-> relay_close_out[0]; endproperty
    a_on: assert property (p_on) else $error("relay open");
    c_on: cover property ($rose(state_out[0]));
    c_done: cover property (done_out[0]);
    c_wr: cover property (member_wr_in);
endmodule
bind oecs_top oecs_top_sva #(.OFF_DRAIN_CYC(OFF_DRAIN_CYC),
    .OFF_RELAY_CYC(OFF_RELAY_CYC)) u_sva (.*);

// file: tb_top.sv
// Testbench driving requests and writes as one-cycle pulses.
// Assumes small phase counts, so each sequence takes tens to hundreds of cycles.
`timescale 1ns/1ns
module tb_top;
    logic mclk_in, arst_n_in, dr, cv, con, kp, rw, mw, ow, sw, src, pon, poff;
    logic cen, so;
    logic [3:0] ch, dch, mem, st, rly, done, mo, bsy;
    logic [20:0] dly, ofs, oo, eff, rr, fr;
    logic [55:0] lst;
    logic [2:0] len;
    logic [83:0] stg;
    int error_cnt, total_checks;
    oecs_stage_model u_stage (.stage_off_out(stg));
    oecs_top #(20, 40, 20, 20) DUT (.mclk_in, .arst_n_in, .dev_reset_in(dr),
        .cmd_valid_in(cv), .cmd_on_in(con), .keep_relays_qualifier_in(kp),
        .cmd_chans_in(ch), .rise_wr_in(rw), .fall_wr_in(rw),
        .dly_chans_in(dch), .dly_us_in(dly), .dly_sel_in(2'h1),
        .couple_en_in(cen), .member_wr_in(mw), .member_in(mem),
        .offset_wr_in(ow), .offset_us_in(ofs), .source_wr_in(sw),
        .offset_source_select_in(src), .stage_off_in(stg),
        .pin_on_trig_in(pon), .pin_off_trig_in(poff), .state_out(st),
        .drive_en_out(), .relay_close_out(rly), .busy_out(bsy),
        .done_out(done),
        .member_out(mo), .member_list_out(lst), .member_len_out(len),
        .offset_out(oo), .offset_source_select_out(so), .offset_eff_out(eff),
        .rise_rd_out(rr), .fall_rd_out(fr));
    // Free-running 50 MHz clock.
    initial begin
        mclk_in = 0;
        forever #10 mclk_in = ~mclk_in;
    end
    task chk(input string n, input logic [55:0] g, e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    // One strobe high for a single cycle, all dropped at the next falling edge.
    task go(input int k);
        @(negedge mclk_in);
        case (k)
            0: cv = 1;
            1: mw = 1;
            2: ow = 1;
            3: sw = 1;
            4: rw = 1;
            default: dr = 1;
        endcase
        @(negedge mclk_in);
        {cv, mw, ow, sw, rw, dr} = 0;
    endtask
    task wdone(input int c);
        int i;
        i = 0;
        while (done[c] !== 1'b1 && i < 3000) begin
            @(negedge mclk_in);
            i++;
        end
        chk("done", i < 3000, 1);
        repeat (3) @(negedge mclk_in);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the planned run.
    initial begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        wrap_up;
    end
    // Main sequence.
    initial begin
        {arst_n_in, dr, cv, con, kp, rw, mw, ow, sw, src, pon, poff} = 0;
        {ch, dch, mem, dly, ofs} = 0;
        cen = 1;
        repeat (2) @(negedge mclk_in);
        arst_n_in = 1;
        chk("rst", {st, rly}, 8'h00);
        {con, ch} = 5'h11;
        go(0);
        wdone(0);
        chk("on", {st, rly}, 8'h11);
        {con, kp} = 2'h1;
        go(0);
        wdone(0);
        chk("keep", {st, rly}, 8'h01);
        {kp, dch, dly} = {1'b0, 4'h2, 21'hA};
        go(4);
        repeat (2) @(negedge mclk_in);
        chk("rise", {rr, fr}, {21'hA, 21'hA});
        mem = 4'h5;
        go(1);
        @(negedge mclk_in);
        chk("list", {lst, len, mo}, {56'h31_2C33, 3'h3, 4'h5});
        pon = 1;
        repeat (4) @(negedge mclk_in);
        pon = 0;
        wdone(2);
        chk("pin", st, 4'h5);
        {con, ch} = 5'h04;
        go(0);
        wdone(0);
        chk("cpl", st, 4'h0);
        ofs = 21'h7;
        go(2);
        src = 1;
        go(3);
        chk("eff", {so, eff}, {1'b1, 21'h7});
        go(5);
        chk("keep", {mo, oo}, {4'h5, 21'h7});
        cen = 0;
        {con, ch} = 5'h11;
        go(0);
        wdone(0);
        chk("nocpl", st, 4'h1);
        cen = 1;
        {con, ch} = 5'h11;
        go(0);
        mem = 4'h0;
        go(1);
        repeat (4) @(negedge mclk_in);
        chk("frc", {st, len, bsy}, {4'h0, 3'h0, 4'h1});
        wdone(0);
        wrap_up;
    end
endmodule
